/* snv_pkg.sv */
// constants and types for the serial nonvolatile memory command engine
// Functional notes
// (RQ1) First byte after select falls is an 8-bit op-code; nine codes recognised.
// (RQ2) Select rising before all op-code bits arrive discards it; nothing executes.
// (RQ3) Enable op-code sets the write latch; host sends it before any write.
// (RQ4) Disable op-code clears the latch; no status or array writes while clear.
// (RQ5) Status read shifts status byte out on falling edges, repeating until deselect.
// (RQ6) Status write stores one byte; input bits 1 and 0 ignored, bit 0 reads zero.
// (RQ7) Host holds the write-protect pin steady throughout a status write.
// (RQ8) Normal read takes 16-bit address, then outputs bytes on falling edges.
// (RQ9) Read address increments every byte, wraps to zero, ends only at deselect.
// (RQ10) Array write commits each byte once all eight bits are received.
// (RQ11) Further complete bytes write at incremented wrapping addresses until deselect.
// (RQ12) Fast read adds eight dummy bits after the address, then reads normally.
// (RQ13) Identifier read outputs four bytes over 32 clocks on falling edges.
// (RQ14) After 32 identifier bits, output keeps the last bit until deselect.
// (RQ15) Sleep entered at select rise after sleep op-code unless a clock intervened.
// (RQ16) In sleep, clock and input are ignored and output floats.
// (RQ17) Normal operation resumes within 400 us of select falling in sleep.
// (RQ18) Block-protect bits choose none, upper quarter, upper half or whole array.
// (RQ19) Latch clear blocks writes; status protected when protect bit set and pin low.
// (RQ20) Hold low with select low pauses command, ignores clock, floats read output; identifier read output stays driven.
// (RQ21) Host releases hold at the same clock level it had when hold began.
// (RQ22) Select rising in hold aborts; latch unchanged if op-code not yet recognised.
// (RQ23) Latch clears at select rise ending a recognised write, at reset, after sleep.
// (RQ24) Input sampled on rising clock edges, output changed on falling edges.
// (RQ25) Unknown op-code: ignore input, float output, change nothing until deselect.
package snv_pkg;
  localparam logic [7:0] SET_WRITE_LATCH_CMD = 8'h06;
  localparam logic [7:0] CLEAR_WRITE_LATCH_CMD = 8'h04;
  localparam logic [7:0] STATUS_READ_CMD = 8'h05;
  localparam logic [7:0] STATUS_WRITE_CMD = 8'h01;
  localparam logic [7:0] ARRAY_READ_CMD = 8'h03;
  localparam logic [7:0] ARRAY_WRITE_CMD = 8'h02;
  localparam logic [7:0] IDENTIFIER_READ_CMD = 8'h9f;
  localparam logic [7:0] FAST_ARRAY_READ_CMD = 8'h0b;
  localparam logic [7:0] SLEEP_CMD = 8'hb9;
  // status field positions
  localparam int STATUS_PROTECT_ENABLE_POS = 7;
  localparam int BLOCK_PROTECT_HI_POS = 3;
  localparam int BLOCK_PROTECT_LO_POS = 2;
  localparam int WRITE_ENABLE_LATCH_POS = 1;
  localparam logic [7:0] STATUS_RESET = 8'h00;
  localparam logic [7:0] STATUS_WRITE_MASK = 8'hfc;
  // protected range starts
  localparam logic [15:0] QUARTER_BASE = 16'hc000;
  localparam logic [15:0] HALF_BASE = 16'h8000;
  // timing
  localparam int CLK_PERIOD_PS = 25000;
  localparam int SLEEP_RECOVERY_TIME_US = 400;
  localparam int SLEEP_RECOVERY_CYCLES = (SLEEP_RECOVERY_TIME_US * 1000000) / CLK_PERIOD_PS;
  localparam int SYNC_STAGES = 2;
  typedef enum logic [3:0] {
    SNV_OPCODE = 4'h0, SNV_STATUS_RD = 4'h1, SNV_STATUS_WR = 4'h2, SNV_ADDR = 4'h3,
    SNV_DUMMY = 4'h4, SNV_READ = 4'h5, SNV_WRITE = 4'h6, SNV_IDENT = 4'h7,
    SNV_SLEEP_ARM = 4'h8, SNV_IGNORE = 4'h9, SNV_DONE = 4'ha
  } snv_state_e;
endpackage

/* snv_sync.sv */
// two-flop synchroniser bank for pin inputs
`timescale 1ns/100ps
module snv_sync #(
  parameter int WIDTH = 5,
  parameter logic [WIDTH-1:0] INIT = '0
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // pins
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_ff;

  // first stage feeds only the second stage
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      meta_ff <= INIT;
      sync_out <= INIT;
    end else begin
      meta_ff <= async_in;
      sync_out <= meta_ff;
    end
  end
endmodule

/* snv_mem.sv */
// byte-wide flip-flop storage for the array
`timescale 1ns/100ps
module snv_mem #(
  parameter int ADDR_W = 16
) (
  // clock
  input wire logic clk,
  // write port
  input wire logic wr_en,
  input wire logic [ADDR_W-1:0] wr_addr,
  input wire logic [7:0] wr_data,
  // read port
  input wire logic [ADDR_W-1:0] rd_addr,
  output logic [7:0] rd_data
);
  logic [7:0] cell_ff [0:(1<<ADDR_W)-1];

  // contents are nonvolatile, so no reset
  always_ff @(posedge clk) begin
    if (wr_en) begin
      cell_ff[wr_addr] <= wr_data;
    end
  end

  assign rd_data = cell_ff[rd_addr];
endmodule

/* snv_engine.sv */
// spi command engine of the serial nonvolatile memory
`timescale 1ns/100ps
module snv_engine
  import snv_pkg::*;
#(
  parameter int ADDR_W = 16,
  parameter int RECOVERY_CYCLES = SLEEP_RECOVERY_CYCLES,
  parameter logic [31:0] IDENT_CODE = 32'h5a_7f_12_34 // value arbitrary
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // serial link pins
  input wire logic cs_n,
  input wire logic sck,
  input wire logic si,
  input wire logic hold_n,
  input wire logic wp_n,
  output logic so,
  output logic so_oe,
  // state shown to the system
  output logic asleep
);
  logic cs_n_s, sck_s, si_s, hold_n_s, wp_n_s;
  logic sck_d_ff;
  logic cs_n_d_ff;
  snv_state_e state_ff;
  logic [7:0] shift_ff;
  logic [5:0] bit_cnt_ff;
  logic [ADDR_W-1:0] addr_ff;
  logic [7:0] status_ff;
  logic write_enable_latch_ff;
  logic so_en_ff;
  logic write_cmd_seen;
  logic so_ff;
  logic sleep_ff;
  logic waking_ff;
  logic [31:0] rec_cnt_ff;
  logic [7:0] out_byte_ff;
  logic mem_we;
  logic [7:0] mem_q;
  logic [7:0] in_byte;
  logic rise, fall, cs_rise, cs_fall, active;
  logic protected_addr, status_locked;

  // start from the idle pin levels so no false clock or select edge follows reset
  snv_sync #(.WIDTH(5), .INIT(5'h13)) u_sync (
    .clk(clk),
    .rst_n(rst_n),
    .async_in({cs_n, sck, si, hold_n, wp_n}),
    .sync_out({cs_n_s, sck_s, si_s, hold_n_s, wp_n_s})
  );

  snv_mem #(.ADDR_W(ADDR_W)) u_mem (
    .clk(clk),
    .wr_en(mem_we),
    .wr_addr(addr_ff),
    .wr_data(in_byte),
    .rd_addr(addr_ff),
    .rd_data(mem_q)
  );

  // edge history of synchronised clock and select
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sck_d_ff <= 1'b0;
      cs_n_d_ff <= 1'b1;
    end else begin
      sck_d_ff <= sck_s;
      cs_n_d_ff <= cs_n_s;
    end
  end

  // hold freezes edges so the command pauses rather than aborts
  assign active = !cs_n_s && hold_n_s && !sleep_ff && !waking_ff; // RQ20 RQ16
  assign rise = active && sck_s && !sck_d_ff; // RQ24
  assign fall = active && !sck_s && sck_d_ff; // RQ24
  assign cs_rise = cs_n_s && !cs_n_d_ff;
  assign cs_fall = !cs_n_s && cs_n_d_ff;
  assign in_byte = {shift_ff[6:0], si_s};

  // protection decode
  always_comb begin
    unique case ({status_ff[BLOCK_PROTECT_HI_POS], status_ff[BLOCK_PROTECT_LO_POS]}) // RQ18
      2'b00: protected_addr = 1'b0;
      2'b01: protected_addr = addr_ff >= QUARTER_BASE[ADDR_W-1:0];
      2'b10: protected_addr = addr_ff >= HALF_BASE[ADDR_W-1:0];
      2'b11: protected_addr = 1'b1;
    endcase
  end
  assign status_locked = status_ff[STATUS_PROTECT_ENABLE_POS] && !wp_n_s; // RQ19

  // array write strobe on the eighth data bit
  assign mem_we = rise && state_ff == SNV_WRITE && bit_cnt_ff == 6'd7 && write_enable_latch_ff &&
                  !protected_addr; // RQ10 RQ19

  // a recognised write op-code clears the latch when the frame ends
  assign write_cmd_seen = out_byte_ff == STATUS_WRITE_CMD || out_byte_ff == ARRAY_WRITE_CMD;

  // command sequencer, sampled on rising serial clock
  always_ff @(posedge clk) begin
    if (!rst_n || cs_rise) begin
      state_ff <= SNV_OPCODE; // RQ2 RQ22
      bit_cnt_ff <= 6'd0;
      shift_ff <= 8'h00;
    end else if (rise) begin
      shift_ff <= in_byte;
      bit_cnt_ff <= bit_cnt_ff + 6'd1;
      unique case (state_ff)
        SNV_OPCODE: begin
          if (bit_cnt_ff == 6'd7) begin // RQ1
            bit_cnt_ff <= 6'd0;
            unique case (in_byte)
              SET_WRITE_LATCH_CMD, CLEAR_WRITE_LATCH_CMD: state_ff <= SNV_DONE;
              STATUS_READ_CMD: state_ff <= SNV_STATUS_RD;
              STATUS_WRITE_CMD: state_ff <= SNV_STATUS_WR;
              ARRAY_READ_CMD, ARRAY_WRITE_CMD, FAST_ARRAY_READ_CMD: state_ff <= SNV_ADDR;
              IDENTIFIER_READ_CMD: state_ff <= SNV_IDENT;
              SLEEP_CMD: state_ff <= SNV_SLEEP_ARM;
              default: state_ff <= SNV_IGNORE; // RQ25
            endcase
            out_byte_ff <= in_byte;
          end
        end
        SNV_ADDR: begin
          if (bit_cnt_ff == 6'(ADDR_W - 1)) begin
            bit_cnt_ff <= 6'd0;
            unique case (out_byte_ff)
              ARRAY_WRITE_CMD: state_ff <= SNV_WRITE;
              FAST_ARRAY_READ_CMD: state_ff <= SNV_DUMMY; // RQ12
              default: state_ff <= SNV_READ; // RQ8
            endcase
          end
        end
        SNV_DUMMY, SNV_READ, SNV_WRITE, SNV_STATUS_RD, SNV_STATUS_WR: begin
          if (bit_cnt_ff == 6'd7) begin
            bit_cnt_ff <= 6'd0;
            if (state_ff == SNV_DUMMY) begin
              state_ff <= SNV_READ;
            end else if (state_ff == SNV_STATUS_WR) begin
              state_ff <= SNV_DONE;
            end
          end
        end
        SNV_IDENT: begin
          if (bit_cnt_ff == 6'd32) begin
            bit_cnt_ff <= 6'd32; // RQ14
          end
        end
        SNV_SLEEP_ARM: state_ff <= SNV_DONE; // RQ15
        SNV_IGNORE, SNV_DONE: bit_cnt_ff <= bit_cnt_ff;
        default: state_ff <= SNV_IGNORE;
      endcase
    end
  end

  // address register: loaded serially, advanced per byte with wrap
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      addr_ff <= '0;
    end else if (rise && state_ff == SNV_ADDR) begin
      addr_ff <= {addr_ff[ADDR_W-2:0], si_s};
    end else if (rise && bit_cnt_ff == 6'd7 && state_ff == SNV_WRITE) begin
      addr_ff <= addr_ff + 1'b1; // RQ11
    end else if (rise && bit_cnt_ff == 6'd7 && state_ff == SNV_READ) begin
      addr_ff <= addr_ff + 1'b1; // RQ9 advance on the last rise so the next fall shows the new byte
    end
  end

  // nonvolatile status bits; only the host-writable ones move
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      status_ff <= STATUS_RESET;
    end else if (rise && state_ff == SNV_STATUS_WR && bit_cnt_ff == 6'd7 && write_enable_latch_ff &&
                 !status_locked) begin
      status_ff <= in_byte & STATUS_WRITE_MASK; // RQ6 RQ19 RQ4
    end
  end

  // write-enable latch; a partial op-code leaves the state at op-code, so the latch keeps its value
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      write_enable_latch_ff <= 1'b0; // RQ23
    end else if (sleep_ff && cs_fall) begin
      write_enable_latch_ff <= 1'b0; // RQ23
    end else if (cs_rise && state_ff != SNV_OPCODE && write_cmd_seen) begin
      write_enable_latch_ff <= 1'b0; // RQ23 RQ22
    end else if (rise && state_ff == SNV_OPCODE && bit_cnt_ff == 6'd7) begin
      if (in_byte == SET_WRITE_LATCH_CMD) begin
        write_enable_latch_ff <= 1'b1; // RQ3
      end else if (in_byte == CLEAR_WRITE_LATCH_CMD) begin
        write_enable_latch_ff <= 1'b0; // RQ4
      end
    end
  end

  // serial output shifter, updated on falling serial clock
  // the first falling edge after the last input bit loads the byte; no data before it
  // so_en_ff remembers that driving began, so a released hold turns the pin back on
  always_ff @(posedge clk) begin
    if (!rst_n || cs_rise) begin
      so_ff <= 1'b0;
      so_oe <= 1'b0;
      so_en_ff <= 1'b0;
    end else if (fall) begin
      unique case (state_ff)
        SNV_STATUS_RD: begin
          so_oe <= 1'b1; // RQ5
          so_en_ff <= 1'b1;
          // bit 1 shows the live latch, the others the stored status
          so_ff <= (bit_cnt_ff[2:0] == 3'd6) ? write_enable_latch_ff : status_ff[3'(7 - bit_cnt_ff[2:0])];
        end
        SNV_READ: begin
          so_oe <= 1'b1; // RQ8 RQ12
          so_en_ff <= 1'b1;
          so_ff <= mem_q[3'(7 - bit_cnt_ff[2:0])];
        end
        SNV_IDENT: begin
          so_oe <= 1'b1; // RQ13
          so_en_ff <= 1'b1;
          if (bit_cnt_ff < 6'd32) begin
            so_ff <= IDENT_CODE[5'(31 - bit_cnt_ff[4:0])];
          end
        end
        default: begin
          so_oe <= 1'b0; // RQ25
          so_en_ff <= 1'b0;
        end
      endcase
    end else if (!hold_n_s && (state_ff == SNV_STATUS_RD || state_ff == SNV_READ)) begin
      so_oe <= 1'b0; // RQ20
    end else begin
      so_oe <= so_en_ff; // RQ20
    end
  end

  // sleep entry, cancellation and timed recovery
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sleep_ff <= 1'b0;
      waking_ff <= 1'b0;
      rec_cnt_ff <= 32'h0;
    end else if (cs_rise && state_ff == SNV_SLEEP_ARM) begin
      sleep_ff <= 1'b1; // RQ15
    end else if (sleep_ff && cs_fall) begin
      sleep_ff <= 1'b0;
      waking_ff <= 1'b1;
      rec_cnt_ff <= 32'(RECOVERY_CYCLES - 1); // RQ17
    end else if (waking_ff) begin
      if (rec_cnt_ff == 32'h0) begin
        waking_ff <= 1'b0;
      end else begin
        rec_cnt_ff <= rec_cnt_ff - 32'h1;
      end
    end
  end

  // status byte shown as stored except the live latch bit
  assign so = so_ff;
  assign asleep = sleep_ff | waking_ff; // RQ16
endmodule

/* snv_engine_props.sv */
// pin-level assertions for the memory command engine
`timescale 1ns/100ps
module snv_engine_props #(
  parameter int RECOVERY_CYCLES = 20
) (
  // watched pins
  input wire logic clk,
  input wire logic rst_n,
  input wire logic cs_n,
  input wire logic sck,
  input wire logic si,
  input wire logic hold_n,
  input wire logic wp_n,
  input wire logic so,
  input wire logic so_oe,
  input wire logic asleep
);
  // slack covers the pin synchronisers
  localparam int WAKE_MAX = RECOVERY_CYCLES + 8;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence idle_s;
    cs_n [*6];
  endsequence
  sequence paused_s;
    (!hold_n && !cs_n) [*6];
  endsequence
  oe_idle_a: assert property (idle_s |-> !so_oe)
    else $error("so driven while deselected");
  so_fall_a: assert property ($changed(so) && so_oe && $past(so_oe) |-> !$past(sck, 2))
    else $error("so moved away from a falling clock");
  sleep_entry_a: assert property ($rose(asleep) |-> cs_n)
    else $error("sleep entered while selected");
  sleep_float_a: assert property (asleep |-> !so_oe)
    else $error("so driven in sleep");
  wake_bound_a: assert property ($fell(cs_n) && asleep |-> ##[1:WAKE_MAX] !asleep)
    else $error("wake-up too slow");
  hold_float_a: assert property (paused_s |-> !so_oe)
    else $error("so driven during hold");
  oe_cause_a: assert property ($rose(so_oe) |-> !cs_n && hold_n)
    else $error("so enabled without selection");
  oe_edge_a: assert property ($rose(so_oe) |-> !$past(sck, 2))
    else $error("so enabled off a falling clock");
endmodule

/* snv_host_model.sv */
// spi host model in clock mode 0 driving the memory pins
`timescale 1ns/100ps
module snv_host_model (
  // clock
  input wire logic clk,
  // serial pins
  output logic cs_n,
  output logic sck,
  output logic si,
  output logic hold_n,
  output logic wp_n,
  input wire logic so
);
  // clock idles low outside frames
  initial begin
    cs_n = 1'b1;
    sck = 1'b0;
    si = 1'b0;
    hold_n = 1'b1;
    wp_n = 1'b1;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic sel();
    cs_n = 1'b0;
    tick(4);
  endtask
  // released si flips so a stale level is never read as valid
  task automatic desel();
    tick(4);
    cs_n = 1'b1;
    si = ~si;
    tick(8);
  endtask
  // msb first; si moves while sck low, so taken just before the fall
  task automatic xfer(input logic [7:0] tx, input int nbits, output logic [7:0] rx);
    rx = 8'h00;
    for (int i = 7; i > 7 - nbits; i--) begin
      si = tx[i];
      tick(4);
      sck = 1'b1;
      tick(3);
      rx[i] = so;
      tick(1);
      sck = 1'b0;
    end
  endtask
endmodule

/* tb_snv_engine.sv */
// self-checking bench for the memory command engine
`timescale 1ns/100ps
module tb_snv_engine;
  import snv_pkg::*;
  localparam int RECOV = 20;
  localparam logic [31:0] ID_CODE = 32'hc3_21_0f_a8; // value arbitrary
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic cs_n, sck, si, hold_n, wp_n, so, so_oe, asleep;
  logic [7:0] rx;
  int err_count = 0;
  int checks_done = 0;
  always #12.5 clk = ~clk;
  snv_engine #(.RECOVERY_CYCLES(RECOV), .IDENT_CODE(ID_CODE)) uut (.clk(clk), .rst_n(rst_n), .cs_n(cs_n),
    .sck(sck), .si(si), .hold_n(hold_n), .wp_n(wp_n), .so(so), .so_oe(so_oe), .asleep(asleep));
  snv_host_model host (.clk(clk), .cs_n(cs_n), .sck(sck), .si(si), .hold_n(hold_n), .wp_n(wp_n), .so(so));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic report_and_stop();
    $display("errors %0d checks %0d", err_count, checks_done);
    if (err_count == 0 && checks_done > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic op(input logic [7:0] code);
    host.sel();
    host.xfer(code, 8, rx);
    host.desel();
  endtask
  task automatic rd_stat(input logic [7:0] e);
    host.sel();
    host.xfer(STATUS_READ_CMD, 8, rx);
    repeat (2) begin
      host.xfer(8'h00, 8, rx);
      chk(rx, e);
    end
    host.desel();
  endtask
  task automatic wr_stat(input logic [7:0] d);
    op(SET_WRITE_LATCH_CMD);
    host.sel();
    host.xfer(STATUS_WRITE_CMD, 8, rx);
    host.xfer(d, 8, rx);
    host.desel();
  endtask
  task automatic wr_arr(input logic en, input logic [15:0] a, input logic [7:0] d0, input logic [7:0] d1);
    if (en) op(SET_WRITE_LATCH_CMD);
    host.sel();
    host.xfer(ARRAY_WRITE_CMD, 8, rx);
    host.xfer(a[15:8], 8, rx);
    host.xfer(a[7:0], 8, rx);
    host.xfer(d0, 8, rx);
    host.xfer(d1, 8, rx);
    host.desel();
  endtask
  task automatic rd_open(input logic [7:0] code, input logic [15:0] a);
    host.sel();
    host.xfer(code, 8, rx);
    host.xfer(a[15:8], 8, rx);
    host.xfer(a[7:0], 8, rx);
    if (code == FAST_ARRAY_READ_CMD) host.xfer(8'h00, 8, rx);
  endtask
  task automatic rd_arr(input logic [7:0] code, input logic [15:0] a, input logic [7:0] e0, input logic [7:0] e1);
    rd_open(code, a);
    host.xfer(8'h00, 8, rx);
    chk(rx, e0);
    host.xfer(8'h00, 8, rx);
    chk(rx, e1);
    host.desel();
  endtask
  // watchdog sized well above the expected run
  initial begin
    #400000;
    err_count++;
    report_and_stop();
  end
  initial begin
    repeat (16) @(posedge clk);
    #1 rst_n = 1'b1;
    host.tick(4);
    rd_stat(8'h00);
    op(SET_WRITE_LATCH_CMD);
    rd_stat(8'h02);
    op(CLEAR_WRITE_LATCH_CMD);
    rd_stat(8'h00);
    host.sel();
    host.xfer(SET_WRITE_LATCH_CMD, 4, rx);
    host.desel();
    rd_stat(8'h00);
    wr_arr(1'b1, 16'hbfff, 8'h3c, 8'hf7);
    rd_stat(8'h00);
    rd_arr(ARRAY_READ_CMD, 16'hbfff, 8'h3c, 8'hf7);
    wr_arr(1'b1, 16'hffff, 8'h11, 8'h22);
    rd_arr(ARRAY_READ_CMD, 16'hffff, 8'h11, 8'h22);
    rd_arr(FAST_ARRAY_READ_CMD, 16'hffff, 8'h11, 8'h22);
    wr_arr(1'b0, 16'hbfff, 8'ha0, 8'ha1);
    rd_arr(ARRAY_READ_CMD, 16'hbfff, 8'h3c, 8'hf7);
    wr_stat(8'hff);
    rd_stat(8'hfc);
    wr_arr(1'b1, 16'hffff, 8'h55, 8'h66);
    rd_arr(ARRAY_READ_CMD, 16'hffff, 8'h11, 8'h22);
    host.wp_n = 1'b0;
    wr_stat(8'h04);
    rd_stat(8'hfc);
    host.wp_n = 1'b1;
    wr_stat(8'h04);
    rd_stat(8'h04);
    wr_arr(1'b1, 16'hbfff, 8'h5a, 8'h99);
    rd_arr(ARRAY_READ_CMD, 16'hbfff, 8'h5a, 8'hf7);
    host.sel();
    host.xfer(IDENTIFIER_READ_CMD, 8, rx);
    for (int b = 3; b >= 0; b--) begin
      host.xfer(8'h00, 8, rx);
      chk(rx, ID_CODE[b*8 +: 8]);
    end
    host.xfer(8'h00, 8, rx);
    chk(rx, {8{ID_CODE[0]}});
    host.desel();
    host.sel();
    host.xfer(8'hff, 8, rx);
    host.xfer(SET_WRITE_LATCH_CMD, 8, rx);
    chk({7'h00, so_oe}, 8'h00);
    host.desel();
    rd_stat(8'h04);
    rd_open(ARRAY_READ_CMD, 16'hbfff);
    host.xfer(8'h00, 8, rx);
    host.tick(4); // let the last falling clock land before pausing
    host.hold_n = 1'b0;
    host.tick(6);
    chk({7'h00, so_oe}, 8'h00);
    host.hold_n = 1'b1;
    host.tick(4);
    chk({7'h00, so_oe}, 8'h01);
    host.xfer(8'h00, 8, rx);
    chk(rx, 8'hf7);
    host.desel();
    host.sel();
    host.xfer(SLEEP_CMD, 8, rx);
    host.xfer(8'h00, 1, rx);
    host.desel();
    chk({7'h00, asleep}, 8'h00);
    op(SET_WRITE_LATCH_CMD);
    op(SLEEP_CMD);
    chk({7'h00, asleep}, 8'h01);
    host.sel();
    host.tick(RECOV + 8);
    host.desel();
    chk({7'h00, asleep}, 8'h00);
    rd_stat(8'h04);
    report_and_stop();
  end
endmodule
bind snv_engine snv_engine_props #(.RECOVERY_CYCLES(RECOVERY_CYCLES)) u_props (.clk(clk), .rst_n(rst_n),
  .cs_n(cs_n), .sck(sck), .si(si), .hold_n(hold_n), .wp_n(wp_n), .so(so), .so_oe(so_oe), .asleep(asleep));
